/* pctl_pkg.sv */
package pctl_pkg;

  // Timing base
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned US_PER_MS = 1000;
  // Delay line sampling tick and figures in microseconds
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned DLY_MIN_US = 2 * US_PER_MS;
  localparam int unsigned DLY_MAX_US = 20 * US_PER_MS;
  localparam int unsigned DLY_MIN_TICKS = DLY_MIN_US / TICK_US;
  localparam int unsigned DLY_MAX_TICKS = DLY_MAX_US / TICK_US;
  localparam int unsigned COINC_GND_US = 4 * US_PER_MS;
  localparam int unsigned COINC_PH_US = 3 * US_PER_MS;
  localparam int unsigned LOCKOUT_US = 150 * US_PER_MS;
  // Tick counts; a least time rounds up
  localparam int unsigned COINC_GND_TICKS = (COINC_GND_US + TICK_US - 1) / TICK_US;
  localparam int unsigned COINC_PH_TICKS = (COINC_PH_US + TICK_US - 1) / TICK_US;
  localparam int unsigned LOCKOUT_TICKS = (LOCKOUT_US + TICK_US - 1) / TICK_US;

  // Widths
  localparam int unsigned TW = 16;
  localparam int unsigned DW = 8;

  // Received channel pair
  typedef struct packed {
    logic pos;
    logic neg;
  } pctl_rx_s;

  // Channel supervision states, Gray along normal to lockout path
  typedef enum logic [1:0] {
    CH_OK = 2'b00,
    CH_CLAMP = 2'b01,
    CH_LOCK = 2'b11
  } pctl_ch_e;

  // Subsystem type
  typedef enum logic [1:0] {
    SUB_DUAL = 2'b00,
    SUB_PHASE = 2'b01,
    SUB_GROUND = 2'b10
  } pctl_sub_e;

endpackage : pctl_pkg

/* pctl_top.sv */
`timescale 1ns/1ps
`default_nettype none

module pctl_top #(
  parameter pctl_pkg::pctl_sub_e SUB = pctl_pkg::SUB_DUAL,
  parameter int unsigned DEPTH = pctl_pkg::DLY_MAX_TICKS,
  parameter int unsigned TICK_CYC = pctl_pkg::TICK_CYC,
  parameter int unsigned LOCK_TICKS = pctl_pkg::LOCKOUT_TICKS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Local squaring amplifier and arming
  input wire logic squaring_amplifier,
  input wire logic overreach_fault_detector,
  input wire logic phase_distance_arming,
  input wire logic [pctl_pkg::DW-1:0] local_delay_timer,
  input wire logic trip_clear,
  // Receiver frequency detectors
  input wire logic rx_pos_det,
  input wire logic rx_neg_det,
  // Transmitter keying
  output logic key_pos,
  // Received outputs after supervision
  output logic rx_pos_out,
  output logic rx_neg_out,
  // Trip and alarm
  output logic trip,
  output logic chan_alarm
);

  // Pin synchronisers: stage one read only by stage two
  logic [4:0] s1_q, s2_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else begin
      s1_q <= {squaring_amplifier, overreach_fault_detector, phase_distance_arming,
               rx_pos_det, rx_neg_det};
      s2_q <= s1_q;
    end
  end
  logic sq, arm, det_p, det_n;
  assign sq = s2_q[4];
  assign arm = s2_q[3] | s2_q[2];
  assign det_p = s2_q[1];
  assign det_n = s2_q[0];

  // Clamp a setting into the documented delay range
  function automatic logic [pctl_pkg::DW-1:0] clamp_dly(input logic [pctl_pkg::DW-1:0] v);
    if (v < pctl_pkg::DW'(pctl_pkg::DLY_MIN_TICKS)) return pctl_pkg::DW'(pctl_pkg::DLY_MIN_TICKS);
    if (v > pctl_pkg::DW'(DEPTH)) return pctl_pkg::DW'(DEPTH);
    return v;
  endfunction : clamp_dly

  // Tick divider, one-cycle enable
  logic [pctl_pkg::TW-1:0] div_q, div_d;
  logic tick;
  assign tick = (div_q == pctl_pkg::TW'(TICK_CYC - 1));
  always_comb begin
    div_d = tick ? '0 : div_q + 1'b1;
  end

  // Delay line: sampled shift register, each edge kept to one tick
  logic [DEPTH-1:0] dl_q, dl_d;
  logic [pctl_pkg::DW-1:0] sel;
  logic dly_wave;
  assign sel = clamp_dly(local_delay_timer);
  assign dly_wave = dl_q[sel - 1'b1];
  always_comb begin
    dl_d = dl_q;
    if (tick) dl_d = {dl_q[DEPTH-2:0], sq};
  end

  // Channel supervision
  pctl_pkg::pctl_ch_e ch_q, ch_d;
  logic [pctl_pkg::TW-1:0] loss_q, loss_d;
  logic lost;
  assign lost = ~det_p & ~det_n;
  always_comb begin
    ch_d = ch_q;
    loss_d = loss_q;
    case (ch_q)
      pctl_pkg::CH_OK: begin
        loss_d = '0;
        if (lost) ch_d = pctl_pkg::CH_CLAMP;
      end
      pctl_pkg::CH_CLAMP: begin
        if (!lost) ch_d = pctl_pkg::CH_OK;
        else if (tick) begin
          loss_d = loss_q + 1'b1;
          if (loss_q == pctl_pkg::TW'(LOCK_TICKS - 1)) ch_d = pctl_pkg::CH_LOCK;
        end
      end
      pctl_pkg::CH_LOCK: begin
        if (!lost) ch_d = pctl_pkg::CH_OK; // Channel back ends lockout
      end
      default: ch_d = pctl_pkg::CH_OK;
    endcase
  end

  // Received pair after clamp or lockout
  pctl_pkg::pctl_rx_s rx;
  always_comb begin
    case (ch_d)
      pctl_pkg::CH_CLAMP: rx = '{pos: 1'b1, neg: 1'b1};
      pctl_pkg::CH_LOCK: rx = '{pos: 1'b0, neg: 1'b0};
      default: rx = '{pos: det_p, neg: det_n};
    endcase
  end

  // Comparison gates; segregated negative gate uses inverted received wave
  logic seg, gate_p, gate_n;
  assign seg = (SUB != pctl_pkg::SUB_DUAL);
  assign gate_p = dly_wave & rx_pos_out;
  assign gate_n = ~dly_wave & (seg ? ~rx_pos_out : rx_neg_out);

  // Coincidence timer restarts on any gap, so short pulses never trip
  // Limitation: counting whole ticks, a window may run up to one tick short of the figure
  localparam int unsigned NEED = (SUB == pctl_pkg::SUB_PHASE) ? pctl_pkg::COINC_PH_TICKS
                                                             : pctl_pkg::COINC_GND_TICKS;
  logic [pctl_pkg::TW-1:0] co_q, co_d;
  logic trip_d, coinc;
  assign coinc = gate_p | gate_n;
  always_comb begin
    co_d = co_q;
    if (!coinc || !arm) co_d = '0;
    else if (tick && co_q != pctl_pkg::TW'(NEED)) co_d = co_q + 1'b1;
    trip_d = trip;
    if (trip_clear) trip_d = 1'b0;
    if (co_q == pctl_pkg::TW'(NEED)) trip_d = 1'b1; // set wins
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q <= '0;
      dl_q <= '0;
      ch_q <= pctl_pkg::CH_OK;
      loss_q <= '0;
      co_q <= '0;
      key_pos <= 1'b0;
      rx_pos_out <= 1'b0;
      rx_neg_out <= 1'b0;
      trip <= 1'b0;
      chan_alarm <= 1'b0;
    end else begin
      div_q <= div_d;
      dl_q <= dl_d;
      ch_q <= ch_d;
      loss_q <= loss_d;
      co_q <= co_d;
      key_pos <= sq;
      rx_pos_out <= rx.pos;
      rx_neg_out <= rx.neg;
      trip <= trip_d;
      chan_alarm <= (ch_d == pctl_pkg::CH_LOCK);
    end
  end

  // Checks
  a_key_follows: assert property (@(posedge mclk) disable iff (rst)
    key_pos == $past(sq)) else $error("keying does not follow wave");
  a_lock_low: assert property (@(posedge mclk) disable iff (rst)
    chan_alarm |-> (!rx_pos_out && !rx_neg_out)) else $error("lockout leak");
  a_clamp_high: assert property (@(posedge mclk) disable iff (rst)
    (ch_q == pctl_pkg::CH_CLAMP) |=> (rx_pos_out && rx_neg_out) || chan_alarm || !$past(lost))
    else $error("clamp not high");
  a_alarm_lock: assert property (@(posedge mclk) disable iff (rst)
    chan_alarm |-> ch_q == pctl_pkg::CH_LOCK) else $error("alarm without lockout");
  a_trip_hold: assert property (@(posedge mclk) disable iff (rst)
    (trip && !trip_clear) |=> trip) else $error("trip dropped");
  a_trip_cause: assert property (@(posedge mclk) disable iff (rst)
    $rose(trip) |-> $past(co_q) == pctl_pkg::TW'(NEED)) else $error("trip early");
  a_gap_resets: assert property (@(posedge mclk) disable iff (rst)
    !coinc |=> co_q == '0) else $error("timer kept count");
  a_delay_range: assert property (@(posedge mclk) disable iff (rst)
    sel >= pctl_pkg::DW'(pctl_pkg::DLY_MIN_TICKS) && sel <= pctl_pkg::DW'(DEPTH))
    else $error("delay out of range");

  // Loss of channel walks two steps: clamp at once, lockout after the last loss tick
  sequence s_quiet_healthy;
    ch_q == pctl_pkg::CH_OK && lost;
  endsequence : s_quiet_healthy
  sequence s_both_high;
    rx_pos_out && rx_neg_out;
  endsequence : s_both_high
  sequence s_last_loss_tick;
    ch_q == pctl_pkg::CH_CLAMP && lost && tick && loss_q == pctl_pkg::TW'(LOCK_TICKS - 1);
  endsequence : s_last_loss_tick
  sequence s_locked_low;
    chan_alarm && !rx_pos_out && !rx_neg_out;
  endsequence : s_locked_low
  a_clamp_entry: assert property (@(posedge mclk) disable iff (rst)
    s_quiet_healthy |=> s_both_high) else $error("clamp entry missed");
  a_lock_entry: assert property (@(posedge mclk) disable iff (rst)
    s_last_loss_tick |=> s_locked_low) else $error("lockout entry missed");

  // Timer climbs one step per armed coincident tick, so a stuck count is caught
  a_count_step: assert property (@(posedge mclk) disable iff (rst)
    (arm && coinc && tick && co_q != pctl_pkg::TW'(NEED)) |=> co_q == $past(co_q) + 1'b1)
    else $error("timer missed a tick");

endmodule : pctl_top

`default_nettype wire

/* pctl_remote.sv */
`timescale 1ns/1ps
`default_nettype none

// Remote terminal: returns a keyed wave after a fixed channel delay
module pctl_remote #(
  parameter int DLY = 80
) (
  // Clock
  input wire logic mclk,
  // Local keying and channel conditions
  input wire logic key_in,
  input wire logic invert,
  input wire logic lost,
  // Receiver frequency detections
  output logic rx_pos_det,
  output logic rx_neg_det
);
  logic [DLY-1:0] line_q = '0;
  // Reversed remote current models an external fault
  always_ff @(posedge mclk) begin
    line_q <= {line_q[DLY-2:0], key_in ^ invert};
  end
  // A dead channel leaves both detectors quiet, never a stale tone
  assign rx_pos_det = !lost && line_q[DLY-1];
  assign rx_neg_det = !lost && !line_q[DLY-1];
endmodule : pctl_remote

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic mclk, rst, sq, arm, arm_b, clr, inv, lost;
  logic [7:0] dly_set;
  logic key_pos, rx_pos_det, rx_neg_det, rx_pos_out, rx_neg_out, trip, chan_alarm;
  logic key_b, rx_pos_b, rx_neg_b, trip_b;
  int bad_count = 0;
  int comparisons = 0;

  // Short tick and lockout keep the run brief; 20 ticks of delay match the 80-cycle channel
  pctl_top #(.TICK_CYC(4), .LOCK_TICKS(5)) i_dut (
    .mclk(mclk), .rst(rst), .squaring_amplifier(sq), .overreach_fault_detector(arm),
    .phase_distance_arming(arm_b), .local_delay_timer(dly_set), .trip_clear(clr),
    .rx_pos_det(rx_pos_det), .rx_neg_det(rx_neg_det), .key_pos(key_pos),
    .rx_pos_out(rx_pos_out), .rx_neg_out(rx_neg_out), .trip(trip), .chan_alarm(chan_alarm));

  pctl_remote i_remote (
    .mclk(mclk), .key_in(key_pos), .invert(inv), .lost(lost),
    .rx_pos_det(rx_pos_det), .rx_neg_det(rx_neg_det));

  // Segregated phase subsystem on a channel of its own
  pctl_top #(.SUB(pctl_pkg::SUB_PHASE), .TICK_CYC(4)) i_dut_seg (
    .mclk(mclk), .rst(rst), .squaring_amplifier(sq), .overreach_fault_detector(arm),
    .phase_distance_arming(arm_b), .local_delay_timer(dly_set), .trip_clear(clr),
    .rx_pos_det(rx_pos_b), .rx_neg_det(rx_neg_b), .key_pos(key_b),
    .rx_pos_out(), .rx_neg_out(), .trip(trip_b), .chan_alarm());

  pctl_remote i_remote_seg (
    .mclk(mclk), .key_in(key_b), .invert(inv), .lost(lost),
    .rx_pos_det(rx_pos_b), .rx_neg_det(rx_neg_b));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic check(input logic seen, input logic exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // Keying follows the square wave in both states
  task automatic t_keying;
    sq = 1'b1;
    cyc(5);
    check(key_pos, 1'b1, "key high");
    sq = 1'b0;
    cyc(5);
    check(key_pos, 1'b0, "key low");
    $display("test keying done");
  endtask : t_keying

  // Six half-cycles of 200 cycles (5 ms-equivalent), longer than the 4 ms-equivalent need of 160 cycles
  task automatic t_fault(input logic rev, input logic exp);
    inv = rev;
    arm = 1'b1;
    repeat (6) begin
      sq = ~sq;
      cyc(200);
    end
    check(trip, exp, "trip after fault");
    check(trip_b, exp, "segregated trip after fault");
    $display("test fault done");
  endtask : t_fault

  // Trip latches after arming drops, then clears
  task automatic t_hold;
    arm = 1'b0;
    cyc(400);
    check(trip, 1'b1, "trip held");
    check(trip_b, 1'b1, "segregated trip held");
    clr = 1'b1;
    cyc(2);
    clr = 1'b0;
    cyc(3);
    check(trip, 1'b0, "trip cleared");
    check(trip_b, 1'b0, "segregated trip cleared");
    $display("test hold done");
  endtask : t_hold

  // Delay set 17 ticks past the channel: each window is about 34 ticks long,
  // enough for the 3 ms phase timer, short of the 4 ms dual timer
  task automatic t_skew;
    dly_set = 8'h25;
    arm_b = 1'b1;
    repeat (6) begin
      sq = ~sq;
      cyc(200);
    end
    check(trip, 1'b0, "dual held off by skew");
    check(trip_b, 1'b1, "phase trips on skew");
    arm_b = 1'b0;
    clr = 1'b1;
    cyc(2);
    clr = 1'b0;
    dly_set = 8'h14;
    cyc(3);
    check(trip_b, 1'b0, "phase trip cleared");
    $display("test skew done");
  endtask : t_skew

  // Loss of channel clamps high, then locks out with alarm
  task automatic t_lockout;
    check(rx_pos_out ^ rx_neg_out, 1'b1, "normal receive");
    lost = 1'b1;
    cyc(6);
    check(rx_pos_out & rx_neg_out, 1'b1, "clamp high");
    check(chan_alarm, 1'b0, "no early alarm");
    cyc(34);
    check(rx_pos_out | rx_neg_out, 1'b0, "lockout low");
    check(chan_alarm, 1'b1, "alarm");
    lost = 1'b0;
    cyc(8);
    check(chan_alarm, 1'b0, "alarm gone");
    $display("test lockout done");
  endtask : t_lockout

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("Error %0t: watchdog", $time);
    conclude();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {sq, arm, arm_b, clr, inv, lost} = '0;
    dly_set = 8'h14;
    cyc(2);
    rst = 1'b0;
    cyc(3);
    t_keying();
    t_fault(1'b1, 1'b0);
    t_fault(1'b0, 1'b1);
    t_hold();
    t_skew();
    t_lockout();
    conclude();
  end
endmodule : tb

`default_nettype wire
